// *** logic/clk_prescaler.sv ***
// programmable 1 to 1024 prescaler for the oscillator level
`timescale 1ns/1ns
`default_nettype none
module clk_prescaler import clk_src_pkg::*; (
	input  wire logic clk,
	input  wire logic resetn,
	presc_if.div      bus
);
	logic             oscPrev_r;
	logic             oscPrev_nxt;
	logic [DIV_W-1:0] count_r;
	logic [DIV_W-1:0] count_nxt;
	logic             divOut_r;
	logic             divOut_nxt;
	logic             rise;
	logic [DIV_W:0]   highLimit;

	assign rise = bus.oscLevel && !oscPrev_r;
	assign highLimit = ({1'h0, bus.divField} + HALF_ROUND) >> 1;
	assign bus.divOut = divOut_r;

	always_comb begin
		oscPrev_nxt = bus.oscLevel;
		count_nxt = count_r;
		divOut_nxt = divOut_r;
		if (bus.restart) begin
			// parked at the last count so the first edge starts a high phase
			count_nxt = bus.divField;
			divOut_nxt = 1'h0;
		end else if (bus.divField == DIV_PASS) begin
			divOut_nxt = bus.oscLevel;
		end else begin
			// ten bit field, up to 1023 for a divide by 1024
			if (rise) begin
				count_nxt = (count_r == bus.divField) ? DIV_PASS
					: count_r + CNT_STEP;
			end
			// odd divisors give a high phase one period shorter than the low phase
			divOut_nxt = ({1'h0, count_nxt} < highLimit);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			oscPrev_r <= 1'h0;
			count_r <= DIV_PASS;
			divOut_r <= 1'h0;
		end else begin
			oscPrev_r <= oscPrev_nxt;
			count_r <= count_nxt;
			divOut_r <= divOut_nxt;
		end
	end

	property p_wrap;
		@(posedge clk) disable iff (!resetn)
		(rise && !bus.restart && bus.divField != DIV_PASS
			&& count_r == bus.divField) |=> count_r == DIV_PASS;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("prescaler did not wrap at field value");

	property p_step;
		@(posedge clk) disable iff (!resetn)
		(rise && !bus.restart && bus.divField != DIV_PASS
			&& count_r < bus.divField)
			|=> count_r == $past(count_r) + CNT_STEP;
	endproperty
	a_step: assert property (p_step)
		else $error("prescaler count did not advance");

	property p_pass;
		@(posedge clk) disable iff (!resetn)
		(!bus.restart && bus.divField == DIV_PASS)
			|=> divOut_r == $past(bus.oscLevel);
	endproperty
	a_pass: assert property (p_pass)
		else $error("divide by one did not follow oscillator");

	property p_max;
		@(posedge clk) disable iff (!resetn)
		(rise && !bus.restart && bus.divField == DIV_MAX_FIELD
			&& count_r == DIV_MAX_FIELD) |=> count_r == DIV_PASS;
	endproperty
	a_max: assert property (p_max)
		else $error("divide by 1024 did not wrap");

	c_wrap: cover property (@(posedge clk) disable iff (!resetn)
		rise && count_r == bus.divField && bus.divField != DIV_PASS);
endmodule
`default_nettype wire

// *** logic/system_clock_source_prescaler.sv ***
// system clock source selector with glitch free switching
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - select 11 drives direct input through
// - select 10 with bypass divides oscillator
// - prescaler source crystal or internal, field+1
// - divisor one passes oscillator unchanged
// - divisor reaches 1024 at most
// - select 10 without bypass uses PLL
// - select 00 uses wakeup clock
module system_clock_source_prescaler import clk_src_pkg::*; (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             directClockIn,
	input  wire logic             crystalInput,
	input  wire logic             internalClockIn,
	input  wire logic             pllClockIn,
	input  wire logic             wakeupClockIn,
	input  wire logic             oscSourceSelect,
	input  wire logic [1:0]       clockSourceSelect,
	input  wire logic             vcoBypass,
	input  wire logic [DIV_W-1:0] prescalerDivideField,
	output logic                  sysClk,
	output logic                  pllEnable
);
	presc_if pIf ();

	switch_e          state_r;
	switch_e          state_nxt;
	logic [1:0]       actSel_r;
	logic [1:0]       actSel_nxt;
	logic             actByp_r;
	logic             actByp_nxt;
	logic [DIV_W-1:0] actDiv_r;
	logic [DIV_W-1:0] actDiv_nxt;
	logic             actOsc_r;
	logic             actOsc_nxt;
	logic             sysClk_r;
	logic             sysClk_nxt;
	logic             pllEn_r;
	logic             pllEn_nxt;
	logic             restart;
	logic             srcNow;
	logic             srcNew;
	logic             cfgChange;

	// level of the source a setting picks; reserved code gives a held low
	function automatic logic srcLevel(
		input logic [1:0] sel,
		input logic       byp,
		input logic       divLvl,
		input logic       dir,
		input logic       pll,
		input logic       wu
	);
		case (sel)
			SEL_DIRECT:    srcLevel = dir;
			SEL_PRESC_PLL: srcLevel = byp ? divLvl : pll;
			SEL_WAKEUP:    srcLevel = wu;
			default:       srcLevel = 1'h0;
		endcase
	endfunction

	clk_prescaler u_presc (
		.clk    (clk),
		.resetn (resetn),
		.bus    (pIf)
	);

	assign pIf.oscLevel = actOsc_r ? crystalInput : internalClockIn;
	assign pIf.divField = actDiv_r;
	assign pIf.restart = restart;
	assign sysClk = sysClk_r;
	assign pllEnable = pllEn_r;

	assign cfgChange = (clockSourceSelect != actSel_r)
		|| (vcoBypass != actByp_r)
		|| (prescalerDivideField != actDiv_r)
		|| (oscSourceSelect != actOsc_r);

	always_comb begin
		state_nxt = state_r;
		actSel_nxt = actSel_r;
		actByp_nxt = actByp_r;
		actDiv_nxt = actDiv_r;
		actOsc_nxt = actOsc_r;
		restart = 1'h0;
		srcNow = srcLevel(actSel_r, actByp_r, pIf.divOut,
			directClockIn, pllClockIn, wakeupClockIn);
		// a freshly restarted prescaler always starts low
		srcNew = srcLevel(clockSourceSelect, vcoBypass, 1'h0,
			directClockIn, pllClockIn, wakeupClockIn);
		sysClk_nxt = 1'h0;
		case (state_r)
			RUN: begin
				sysClk_nxt = srcNow;
				// leave only in a low phase, never cut a high one
				if (cfgChange && !srcNow) begin
					state_nxt = SWITCH;
				end
			end
			SWITCH: begin
				// held low until the new source is low too
				// a new source stuck high parks the output low
				if (!srcNew) begin
					actSel_nxt = clockSourceSelect;
					actByp_nxt = vcoBypass;
					actDiv_nxt = prescalerDivideField;
					actOsc_nxt = oscSourceSelect;
					restart = 1'b1;
					state_nxt = RUN;
				end
			end
			default: begin
				state_nxt = RUN;
			end
		endcase
		pllEn_nxt = (actSel_nxt == SEL_PRESC_PLL) && !actByp_nxt;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_r <= RUN;
			actSel_r <= RST_SEL;
			actByp_r <= RST_BYPASS;
			actDiv_r <= RST_DIV;
			actOsc_r <= RST_OSC_XTAL;
			sysClk_r <= 1'h0;
			pllEn_r <= 1'h0;
		end else begin
			state_r <= state_nxt;
			actSel_r <= actSel_nxt;
			actByp_r <= actByp_nxt;
			actDiv_r <= actDiv_nxt;
			actOsc_r <= actOsc_nxt;
			sysClk_r <= sysClk_nxt;
			pllEn_r <= pllEn_nxt;
		end
	end

	property p_direct;
		@(posedge clk) disable iff (!resetn)
		(state_r == RUN && actSel_r == SEL_DIRECT)
			|=> sysClk_r == $past(directClockIn);
	endproperty
	a_direct: assert property (p_direct)
		else $error("direct drive not followed");

	property p_presc;
		@(posedge clk) disable iff (!resetn)
		(state_r == RUN && actSel_r == SEL_PRESC_PLL && actByp_r)
			|=> sysClk_r == $past(pIf.divOut);
	endproperty
	a_presc: assert property (p_presc)
		else $error("prescaler output not selected");

	property p_pll;
		@(posedge clk) disable iff (!resetn)
		(state_r == RUN && actSel_r == SEL_PRESC_PLL && !actByp_r)
			|=> pllEn_r && sysClk_r == $past(pllClockIn);
	endproperty
	a_pll: assert property (p_pll)
		else $error("pll operation not selected");

	property p_wakeup;
		@(posedge clk) disable iff (!resetn)
		(state_r == RUN && actSel_r == SEL_WAKEUP)
			|=> !pllEn_r && sysClk_r == $past(wakeupClockIn);
	endproperty
	a_wakeup: assert property (p_wakeup)
		else $error("wakeup clock not selected");

	property p_low_in_switch;
		@(posedge clk) disable iff (!resetn)
		(state_r == SWITCH) |-> !sysClk_r;
	endproperty
	a_low_in_switch: assert property (p_low_in_switch)
		else $error("output high while switching");

	property p_no_cut;
		@(posedge clk) disable iff (!resetn)
		(state_r == RUN && cfgChange && srcNow)
			|=> state_r == RUN && sysClk_r;
	endproperty
	a_no_cut: assert property (p_no_cut)
		else $error("high phase cut by a switch");

	property p_hold;
		@(posedge clk) disable iff (!resetn)
		(state_r == SWITCH && srcNew)
			|=> state_r == SWITCH && actSel_r == $past(actSel_r);
	endproperty
	a_hold: assert property (p_hold)
		else $error("switch taken while new source high");

	property p_load;
		@(posedge clk) disable iff (!resetn)
		(state_r == SWITCH && !srcNew)
			|=> state_r == RUN && actSel_r == $past(clockSourceSelect)
			&& actDiv_r == $past(prescalerDivideField);
	endproperty
	a_load: assert property (p_load)
		else $error("new clock setting not loaded");

	property p_restart_low;
		@(posedge clk) disable iff (!resetn)
		restart |=> !pIf.divOut;
	endproperty
	a_restart_low: assert property (p_restart_low)
		else $error("prescaler not low after restart");

	property p_pll_only;
		@(posedge clk) disable iff (!resetn)
		pllEn_r |-> actSel_r == SEL_PRESC_PLL && !actByp_r;
	endproperty
	a_pll_only: assert property (p_pll_only)
		else $error("pll enabled outside pll operation");

	c_switch: cover property (@(posedge clk) disable iff (!resetn)
		state_r == SWITCH ##1 state_r == RUN);
	c_presc: cover property (@(posedge clk) disable iff (!resetn)
		state_r == RUN && actSel_r == SEL_PRESC_PLL && actByp_r
		&& actDiv_r != DIV_PASS && sysClk_r);
	c_direct: cover property (@(posedge clk) disable iff (!resetn)
		state_r == RUN && actSel_r == SEL_DIRECT && sysClk_r);
endmodule
`default_nettype wire

// *** pkg/clk_src_pkg.sv ***
// constants for the system clock source selector and prescaler
package clk_src_pkg;
	localparam int          DIV_W         = 10;
	localparam logic [1:0]  SEL_WAKEUP    = 2'h0;
	localparam logic [1:0]  SEL_RESERVED  = 2'h1;
	localparam logic [1:0]  SEL_PRESC_PLL = 2'h2;
	localparam logic [1:0]  SEL_DIRECT    = 2'h3;
	localparam logic [DIV_W-1:0] DIV_PASS      = 10'h000;
	localparam logic [DIV_W-1:0] DIV_MAX_FIELD = 10'h3ff;
	localparam logic [DIV_W-1:0] CNT_STEP      = 10'h001;
	localparam logic [DIV_W:0]   HALF_ROUND    = 11'h001;
	localparam logic [1:0]  RST_SEL       = SEL_WAKEUP;
	localparam logic        RST_BYPASS    = 1'h0;
	localparam logic [DIV_W-1:0] RST_DIV       = DIV_PASS;
	localparam logic        RST_OSC_XTAL  = 1'h1;
	typedef enum logic [0:0] {RUN, SWITCH} switch_e;
endpackage

// *** pkg/presc_if.sv ***
// carrier between the clock selector and its prescaler
`timescale 1ns/1ns
`default_nettype none
interface presc_if import clk_src_pkg::*;;
	logic             oscLevel;
	logic [DIV_W-1:0] divField;
	logic             restart;
	logic             divOut;
	modport ctl (output oscLevel, output divField, output restart,
		input divOut);
	modport div (input oscLevel, input divField, input restart,
		output divOut);
endinterface
`default_nettype wire

// *** tb/system_clock_source_prescaler_tb.sv ***
// self-checking bench for the system clock source selector
`timescale 1ns/1ns
`default_nettype none
module system_clock_source_prescaler_tb import clk_src_pkg::*;;
	logic             clk;
	logic             resetn;
	logic             oscSel;
	logic             byp;
	logic             sysClk;
	logic             pllEnable;
	logic [1:0]       sel;
	logic [DIV_W-1:0] field;
	int               cnt = 0;
	int               errors;
	int               comparisons;
	// sources get distinct periods so a wrong path shows, except internal and PLL, which match
	wire logic dirIn  = (cnt % 3) == 0;
	wire logic xtalIn = (cnt % 5) < 2;
	wire logic intIn  = (cnt % 4) < 2;
	wire logic pllIn  = (cnt % 4) < 2;
	wire logic wuIn   = (cnt % 6) < 2;

	system_clock_source_prescaler i_dut (
		.clk                  (clk),
		.resetn               (resetn),
		.directClockIn        (dirIn),
		.crystalInput         (xtalIn),
		.internalClockIn      (intIn),
		.pllClockIn           (pllIn),
		.wakeupClockIn        (wuIn),
		.oscSourceSelect      (oscSel),
		.clockSourceSelect    (sel),
		.vcoBypass            (byp),
		.prescalerDivideField (field),
		.sysClk               (sysClk),
		.pllEnable            (pllEnable)
	);

	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) cnt <= #1 cnt + 1;

	task close_out;
		if (errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task cmpN(input int got, input int exp);
		comparisons++;
		if (got != exp) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task cmpB(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// bounded wait; sampling on the falling edge keeps clear of updates
	task waitLvl(input logic v, output int n);
		n = 0;
		while (sysClk !== v && n < 6000) begin
			@(negedge clk);
			n++;
		end
		if (n >= 6000)
			errors++;
	endtask

	task measure(input int expHi, input int expPer);
		int n;
		int hi;
		int lo;
		waitLvl(1'h0, n);
		waitLvl(1'h1, n);
		waitLvl(1'h0, hi);
		waitLvl(1'h1, lo);
		cmpN(hi, expHi);
		cmpN(hi + lo, expPer);
	endtask

	// a switch waits for low source levels, so allow it time to land
	task setCfg(input logic [1:0] s, input logic b,
		input logic [DIV_W-1:0] f, input logic o);
		@(posedge clk);
		#1;
		sel = s;
		byp = b;
		field = f;
		oscSel = o;
		repeat (20) @(negedge clk);
	endtask

	task follow(input logic [1:0] s, input logic b, input int hi,
		input int per, input logic pe);
		setCfg(s, b, DIV_PASS, 1'h1);
		measure(hi, per);
		cmpB(pllEnable, pe);
	endtask

	task presc(input logic o, input logic [DIV_W-1:0] f,
		input int oPer, input int oHi);
		int k;
		k = int'(f) + 1;
		setCfg(SEL_PRESC_PLL, 1'h1, f, o);
		if (k == 1)
			measure(oHi, oPer);
		else
			measure((k / 2) * oPer, k * oPer);
		cmpB(pllEnable, 1'h0);
	endtask

	task reservedSel;
		int i;
		setCfg(SEL_RESERVED, 1'h0, DIV_PASS, 1'h1);
		for (i = 0; i < 12; i++) begin
			@(negedge clk);
			cmpB(sysClk, 1'h0);
		end
		cmpB(pllEnable, 1'h0);
	endtask

	// reset in mid run drops both outputs and returns to wakeup
	task midReset;
		@(posedge clk);
		#1;
		resetn = 1'h0;
		sel = SEL_WAKEUP;
		byp = 1'h0;
		field = DIV_PASS;
		oscSel = 1'h1;
		repeat (4) @(posedge clk);
		#1;
		cmpB(sysClk, 1'h0);
		cmpB(pllEnable, 1'h0);
		resetn = 1'h1;
		measure(2, 6);
		cmpB(pllEnable, 1'h0);
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		close_out;
	end

	initial begin
		resetn = 1'h0;
		sel = SEL_WAKEUP;
		byp = 1'h0;
		field = DIV_PASS;
		oscSel = 1'h1;
		errors = 0;
		comparisons = 0;
		repeat (4) @(posedge clk);
		#1;
		cmpB(sysClk, 1'h0);
		cmpB(pllEnable, 1'h0);
		resetn = 1'h1;
		follow(SEL_WAKEUP, 1'h0, 2, 6, 1'h0);
		follow(SEL_DIRECT, 1'h0, 1, 3, 1'h0);
		follow(SEL_PRESC_PLL, 1'h0, 2, 4, 1'h1);
		midReset;
		presc(1'h1, DIV_PASS, 5, 2);
		presc(1'h1, 10'h002, 5, 2);
		presc(1'h0, 10'h002, 4, 2);
		presc(1'h1, DIV_MAX_FIELD, 5, 2);
		follow(SEL_DIRECT, 1'h0, 1, 3, 1'h0);
		reservedSel;
		close_out;
	end
endmodule
`default_nettype wire
